// ### rtl/sync_mailbox_config_checker.sv
// Checks sync cycle and mailbox setup, runs the state machine and the register slave.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ns
module sync_mailbox_config_checker #(
  parameter int BLINK_HALF_CYCLES = cfg_check_pkg::BLINK_HALF_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  output logic             err_led,
  output logic      [3:0]  esm_state,
  output logic      [15:0] al_status_code
);

  // ****************************************************************
  // Bus slave handshake.
  // ****************************************************************
  logic        ack_r;
  logic        wr_en;
  logic        rd_load;
  logic [31:0] rd_mux;
  logic [31:0] readdata_r;

  // Every access waits one cycle; the write lands at the edge that ends it.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_en           = avs_write && ack_r;
  assign rd_load         = avs_read && !ack_r;
  assign avs_readdata    = readdata_r;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  logic [15:0] mbx_out_start_r;
  logic [15:0] mbx_out_len_r;
  logic [7:0]  mbx_out_ctrl_r;
  logic [15:0] mbx_in_start_r;
  logic [15:0] mbx_in_len_r;
  logic [7:0]  mbx_in_ctrl_r;
  logic [31:0] sync_cycle_r;
  logic [31:0] cycle_obj_r;
  logic [1:0]  sync_mode_r;
  logic [15:0] pd_out_start_r;
  logic [15:0] pd_out_len_r;
  logic [15:0] pd_in_start_r;
  logic [15:0] pd_in_len_r;

  localparam int IRQ_W = cfg_check_pkg::IRQ_WIDTH;

  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;

  logic [31:0] wd;
  logic        wr_state;
  logic        clr_req;
  logic [3:0]  req_code;

  assign wd       = avs_writedata;
  assign wr_state = wr_en && (avs_address == cfg_check_pkg::IDX_STATE_REQ) &&
                    avs_byteenable[0];
  assign clr_req  = wr_state && wd[cfg_check_pkg::REQ_CLEAR_BIT];
  assign req_code = wd[3:0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mbx_out_start_r <= 16'h0000;
      mbx_out_len_r   <= 16'h0000;
      mbx_out_ctrl_r  <= 8'h00;
      mbx_in_start_r  <= 16'h0000;
      mbx_in_len_r    <= 16'h0000;
      mbx_in_ctrl_r   <= 8'h00;
      sync_cycle_r    <= cfg_check_pkg::REG_RESET;
      cycle_obj_r     <= cfg_check_pkg::REG_RESET;
      sync_mode_r     <= cfg_check_pkg::MODE_FREERUN;
      pd_out_start_r  <= 16'h0000;
      pd_out_len_r    <= 16'h0000;
      pd_in_start_r   <= 16'h0000;
      pd_in_len_r     <= 16'h0000;
      irq_mask_r      <= '0;
    end else if (wr_en) begin
      case (avs_address)
        cfg_check_pkg::IDX_MBX_OUT_START: begin
          mbx_out_start_r <= 16'(merge({16'h0000, mbx_out_start_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_MBX_OUT_LEN: begin
          mbx_out_len_r <= 16'(merge({16'h0000, mbx_out_len_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_MBX_OUT_CTRL: begin
          mbx_out_ctrl_r <= 8'(merge({24'h000000, mbx_out_ctrl_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_MBX_IN_START: begin
          mbx_in_start_r <= 16'(merge({16'h0000, mbx_in_start_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_MBX_IN_LEN: begin
          mbx_in_len_r <= 16'(merge({16'h0000, mbx_in_len_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_MBX_IN_CTRL: begin
          mbx_in_ctrl_r <= 8'(merge({24'h000000, mbx_in_ctrl_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_SYNC_CYCLE: begin
          sync_cycle_r <= merge(sync_cycle_r, wd, avs_byteenable);
        end
        cfg_check_pkg::IDX_CYCLE_OBJ: begin
          cycle_obj_r <= merge(cycle_obj_r, wd, avs_byteenable);
        end
        cfg_check_pkg::IDX_SYNC_MODE: begin
          sync_mode_r <= 2'(merge({30'h00000000, sync_mode_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_PD_OUT_START: begin
          pd_out_start_r <= 16'(merge({16'h0000, pd_out_start_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_PD_OUT_LEN: begin
          pd_out_len_r <= 16'(merge({16'h0000, pd_out_len_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_PD_IN_START: begin
          pd_in_start_r <= 16'(merge({16'h0000, pd_in_start_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_PD_IN_LEN: begin
          pd_in_len_r <= 16'(merge({16'h0000, pd_in_len_r}, wd, avs_byteenable));
        end
        cfg_check_pkg::IDX_IRQ_MASK: begin
          irq_mask_r <= IRQ_W'(merge({29'h00000000, irq_mask_r}, wd, avs_byteenable));
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Sync cycle check.
  // ****************************************************************
  logic reg_period_ok;
  logic obj_period_ok;
  logic sync_bad;

  period_check u_reg_period (
    .period    (sync_cycle_r),
    .supported (reg_period_ok)
  );

  period_check u_obj_period (
    .period    (cycle_obj_r),
    .supported (obj_period_ok)
  );

  assign sync_bad =
    ((sync_mode_r == cfg_check_pkg::MODE_DC) &&
     (!reg_period_ok || !obj_period_ok ||
      (sync_cycle_r != cycle_obj_r))) ||
    ((sync_mode_r == cfg_check_pkg::MODE_SM2) && !obj_period_ok);

  // ****************************************************************
  // Mailbox setup check.
  // ****************************************************************
  logic [16:0] out_end;
  logic [16:0] in_end;
  logic        addr_bad;
  logic        odd_bad;
  logic        len_bad;
  logic        ctrl_bad;
  logic [4:0]  ovl;
  logic        mbx_bad;

  assign out_end  = {1'b0, mbx_out_start_r} + {1'b0, mbx_out_len_r};
  assign in_end   = {1'b0, mbx_in_start_r} + {1'b0, mbx_in_len_r};
  // A buffer must lie inside the process memory.
  assign addr_bad = ({1'b0, mbx_out_start_r} < cfg_check_pkg::MEM_START) ||
                    (out_end > cfg_check_pkg::MEM_END) ||
                    ({1'b0, mbx_in_start_r} < cfg_check_pkg::MEM_START) ||
                    (in_end > cfg_check_pkg::MEM_END);
  assign odd_bad  = mbx_out_start_r[0] || mbx_in_start_r[0];
  assign len_bad  = (mbx_out_len_r < cfg_check_pkg::MBX_MIN_LEN) ||
                    (mbx_in_len_r < cfg_check_pkg::MBX_MIN_LEN);
  assign ctrl_bad = (mbx_out_ctrl_r[3:0] != cfg_check_pkg::MBX_OUT_CODE) ||
                    (mbx_in_ctrl_r[3:0] != cfg_check_pkg::MBX_IN_CODE);

  range_overlap u_ovl_mbx (
    .a_start (mbx_out_start_r),
    .a_len   (mbx_out_len_r),
    .b_start (mbx_in_start_r),
    .b_len   (mbx_in_len_r),
    .overlap (ovl[0])
  );

  range_overlap u_ovl_out_pdo (
    .a_start (mbx_out_start_r),
    .a_len   (mbx_out_len_r),
    .b_start (pd_out_start_r),
    .b_len   (pd_out_len_r),
    .overlap (ovl[1])
  );

  range_overlap u_ovl_out_pdi (
    .a_start (mbx_out_start_r),
    .a_len   (mbx_out_len_r),
    .b_start (pd_in_start_r),
    .b_len   (pd_in_len_r),
    .overlap (ovl[2])
  );

  range_overlap u_ovl_in_pdo (
    .a_start (mbx_in_start_r),
    .a_len   (mbx_in_len_r),
    .b_start (pd_out_start_r),
    .b_len   (pd_out_len_r),
    .overlap (ovl[3])
  );

  range_overlap u_ovl_in_pdi (
    .a_start (mbx_in_start_r),
    .a_len   (mbx_in_len_r),
    .b_start (pd_in_start_r),
    .b_len   (pd_in_len_r),
    .overlap (ovl[4])
  );

  assign mbx_bad = addr_bad || odd_bad || len_bad || ctrl_bad ||
                   ovl[0] ||
                   (|ovl[4:1]);

  // ****************************************************************
  // State machine and alarms.
  // ****************************************************************
  cfg_check_pkg::esm_state_t esm_r;
  cfg_check_pkg::esm_state_t esm_nxt;
  logic        sync_alarm_r;
  logic        mbx_alarm_r;
  logic [15:0] al_code_r;
  logic        sync_set;
  logic        mbx_set;
  logic        alarm_any;
  logic        mbx_live_fail;

  assign alarm_any     = sync_alarm_r || mbx_alarm_r;
  assign mbx_live_fail = (esm_r != cfg_check_pkg::ST_INIT) && mbx_bad && !mbx_alarm_r;

  always_comb begin
    esm_nxt  = esm_r;
    sync_set = 1'b0;
    mbx_set  = 1'b0;
    if (mbx_live_fail) begin
      esm_nxt = cfg_check_pkg::ST_INIT;
      mbx_set = 1'b1;
    end else if (wr_state && !alarm_any) begin
      case (esm_r)
        cfg_check_pkg::ST_INIT: begin
          if (req_code == cfg_check_pkg::CODE_PREOP) begin
            if (mbx_bad) begin
              mbx_set = 1'b1;
            end else begin
              esm_nxt = cfg_check_pkg::ST_PREOP;
            end
          end
        end
        cfg_check_pkg::ST_PREOP: begin
          if (req_code == cfg_check_pkg::CODE_INIT) begin
            esm_nxt = cfg_check_pkg::ST_INIT;
          end else if (req_code == cfg_check_pkg::CODE_SAFEOP) begin
            if (sync_bad) begin
              sync_set = 1'b1;
            end else begin
              esm_nxt = cfg_check_pkg::ST_SAFEOP;
            end
          end
        end
        cfg_check_pkg::ST_SAFEOP: begin
          if (req_code == cfg_check_pkg::CODE_INIT) begin
            esm_nxt = cfg_check_pkg::ST_INIT;
          end else if (req_code == cfg_check_pkg::CODE_PREOP) begin
            esm_nxt = cfg_check_pkg::ST_PREOP;
          end else if (req_code == cfg_check_pkg::CODE_OP) begin
            esm_nxt = cfg_check_pkg::ST_OP;
          end
        end
        cfg_check_pkg::ST_OP: begin
          if (req_code == cfg_check_pkg::CODE_INIT) begin
            esm_nxt = cfg_check_pkg::ST_INIT;
          end else if (req_code == cfg_check_pkg::CODE_PREOP) begin
            esm_nxt = cfg_check_pkg::ST_PREOP;
          end else if (req_code == cfg_check_pkg::CODE_SAFEOP) begin
            esm_nxt = cfg_check_pkg::ST_SAFEOP;
          end
        end
        default: begin
          esm_nxt = cfg_check_pkg::ST_INIT;
        end
      endcase
    end
  end

  // A new alarm in the cycle of a clear wins over the clear.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      esm_r        <= cfg_check_pkg::ST_INIT;
      sync_alarm_r <= 1'b0;
      mbx_alarm_r  <= 1'b0;
      al_code_r    <= cfg_check_pkg::AL_CODE_NONE;
    end else begin
      esm_r        <= esm_nxt;
      sync_alarm_r <= sync_set || (sync_alarm_r && !clr_req);
      mbx_alarm_r  <= mbx_set || (mbx_alarm_r && !clr_req);
      if (mbx_set) begin
        al_code_r <= cfg_check_pkg::AL_CODE_MBX;
      end else if (sync_set) begin
        al_code_r <= cfg_check_pkg::AL_CODE_SYNC;
      end else if (clr_req) begin
        al_code_r <= cfg_check_pkg::AL_CODE_NONE;
      end
    end
  end

  assign esm_state = (esm_r == cfg_check_pkg::ST_PREOP)  ? cfg_check_pkg::CODE_PREOP  :
                     (esm_r == cfg_check_pkg::ST_SAFEOP) ? cfg_check_pkg::CODE_SAFEOP :
                     (esm_r == cfg_check_pkg::ST_OP)     ? cfg_check_pkg::CODE_OP     :
                                                           cfg_check_pkg::CODE_INIT;
  assign al_status_code = al_code_r;

  // ****************************************************************
  // Error indicator blinking.
  // ****************************************************************
  logic [31:0] blink_cnt_r;
  logic        led_r;
  logic        blink_wrap;

  assign blink_wrap = (blink_cnt_r == 32'(BLINK_HALF_CYCLES - 1));
  assign err_led    = led_r;

  always_ff @(posedge clk_sys) begin
    if (reset || !alarm_any) begin
      blink_cnt_r <= 32'h00000000;
      led_r       <= 1'b0;
    end else if (blink_wrap) begin
      blink_cnt_r <= 32'h00000000;
      led_r       <= !led_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h00000001;
    end
  end

  // ****************************************************************
  // Interrupt status and read path.
  // ****************************************************************
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_events[cfg_check_pkg::IRQ_SYNC_BIT]  = sync_set;
  assign irq_events[cfg_check_pkg::IRQ_MBX_BIT]   = mbx_set;
  assign irq_events[cfg_check_pkg::IRQ_STATE_BIT] = (esm_nxt != esm_r);
  assign irq_clr = (wr_en && (avs_address == cfg_check_pkg::IDX_IRQ_STATUS) &&
                    avs_byteenable[0]) ? wd[IRQ_W-1:0] : '0;
  assign irq     = |(irq_status_r & irq_mask_r);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_status_r <= '0;
      ack_r        <= 1'b0;
      readdata_r   <= cfg_check_pkg::REG_RESET;
    end else begin
      irq_status_r <= irq_events | (irq_status_r & ~irq_clr);
      ack_r        <= (avs_read || avs_write) && !ack_r;
      if (rd_load) begin
        readdata_r <= rd_mux;
      end
    end
  end

  logic [31:0] stat_word;

  assign stat_word = {al_code_r, 5'h00, led_r, mbx_alarm_r, sync_alarm_r, 4'h0, esm_state};

  assign rd_mux =
    (avs_address == cfg_check_pkg::IDX_MBX_OUT_START) ? {16'h0000, mbx_out_start_r} :
    (avs_address == cfg_check_pkg::IDX_MBX_OUT_LEN)   ? {16'h0000, mbx_out_len_r}   :
    (avs_address == cfg_check_pkg::IDX_MBX_OUT_CTRL)  ? {24'h000000, mbx_out_ctrl_r} :
    (avs_address == cfg_check_pkg::IDX_MBX_IN_START)  ? {16'h0000, mbx_in_start_r}  :
    (avs_address == cfg_check_pkg::IDX_MBX_IN_LEN)    ? {16'h0000, mbx_in_len_r}    :
    (avs_address == cfg_check_pkg::IDX_MBX_IN_CTRL)   ? {24'h000000, mbx_in_ctrl_r} :
    (avs_address == cfg_check_pkg::IDX_SYNC_CYCLE)    ? sync_cycle_r                :
    (avs_address == cfg_check_pkg::IDX_CYCLE_OBJ)     ? cycle_obj_r                 :
    (avs_address == cfg_check_pkg::IDX_SYNC_MODE)     ? {30'h00000000, sync_mode_r} :
    (avs_address == cfg_check_pkg::IDX_PD_OUT_START)  ? {16'h0000, pd_out_start_r}  :
    (avs_address == cfg_check_pkg::IDX_PD_OUT_LEN)    ? {16'h0000, pd_out_len_r}    :
    (avs_address == cfg_check_pkg::IDX_PD_IN_START)   ? {16'h0000, pd_in_start_r}   :
    (avs_address == cfg_check_pkg::IDX_PD_IN_LEN)     ? {16'h0000, pd_in_len_r}     :
    (avs_address == cfg_check_pkg::IDX_STATE_STAT)    ? stat_word                   :
    (avs_address == cfg_check_pkg::IDX_IRQ_STATUS)    ? {29'h00000000, irq_status_r} :
    (avs_address == cfg_check_pkg::IDX_IRQ_MASK)      ? {29'h00000000, irq_mask_r}  :
                                                        32'h00000000;

endmodule

// ### rtl/cfg_check_pkg.sv
// Constants shared by the synchronisation and mailbox setup checker.
// Function
// - DC mode: cycle register or object not one of six periods raises sync cycle alarm.
// - DC mode: cycle register differing from cycle object raises sync cycle alarm.
// - Sync check at PreOP to SafeOP; failure stays PreOP, code 0035h, indicator blinks.
// - SM2 mode: only cycle object checked; failure stays PreOP with code 0035h.
// - Invalid start address of mailbox out or in buffer raises mailbox setup alarm.
// - Mailbox receive range overlapping transmit range raises mailbox setup alarm.
// - Either mailbox range overlapping a process data range raises mailbox setup alarm.
// - Odd start address of either mailbox buffer raises mailbox setup alarm.
// - Mailbox out or in length below 32 bytes raises mailbox setup alarm.
// - Mailbox out control bits 3 to 0 not 0110b raise mailbox setup alarm.
// - Mailbox in control bits 3 to 0 not 0010b raise mailbox setup alarm.
// - Mailbox checked from Init to PreOP and in PreOP, SafeOP, OP; failure gives Init, 0016h.
package cfg_check_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [11:0] IDX_MBX_OUT_START = 12'h800;
  localparam logic [11:0] IDX_MBX_OUT_LEN   = 12'h802;
  localparam logic [11:0] IDX_MBX_OUT_CTRL  = 12'h804;
  localparam logic [11:0] IDX_MBX_IN_START  = 12'h808;
  localparam logic [11:0] IDX_MBX_IN_LEN    = 12'h80a;
  localparam logic [11:0] IDX_MBX_IN_CTRL   = 12'h80c;
  localparam logic [11:0] IDX_SYNC_CYCLE    = 12'h9a0;
  localparam logic [11:0] IDX_CYCLE_OBJ     = 12'ha00;
  localparam logic [11:0] IDX_SYNC_MODE     = 12'ha01;
  localparam logic [11:0] IDX_PD_OUT_START  = 12'ha02;
  localparam logic [11:0] IDX_PD_OUT_LEN    = 12'ha03;
  localparam logic [11:0] IDX_PD_IN_START   = 12'ha04;
  localparam logic [11:0] IDX_PD_IN_LEN     = 12'ha05;
  localparam logic [11:0] IDX_STATE_REQ     = 12'ha06;
  localparam logic [11:0] IDX_STATE_STAT    = 12'ha07;
  localparam logic [11:0] IDX_IRQ_STATUS    = 12'ha08;
  localparam logic [11:0] IDX_IRQ_MASK      = 12'ha09;

  // ****************************************************************
  // Field layouts, codes and reset values.
  // ****************************************************************
  localparam int          REQ_CLEAR_BIT   = 4;
  localparam int          STAT_SYNC_BIT   = 8;
  localparam int          STAT_MBX_BIT    = 9;
  localparam int          STAT_LED_BIT    = 10;
  localparam int          IRQ_SYNC_BIT    = 0;
  localparam int          IRQ_MBX_BIT     = 1;
  localparam int          IRQ_STATE_BIT   = 2;
  localparam int          IRQ_WIDTH       = 3;
  localparam logic [3:0]  CODE_INIT       = 4'h1;
  localparam logic [3:0]  CODE_PREOP      = 4'h2;
  localparam logic [3:0]  CODE_SAFEOP     = 4'h4;
  localparam logic [3:0]  CODE_OP         = 4'h8;
  localparam logic [1:0]  MODE_FREERUN    = 2'h0;
  localparam logic [1:0]  MODE_SM2        = 2'h1;
  localparam logic [1:0]  MODE_DC         = 2'h2;
  localparam logic [15:0] AL_CODE_MBX     = 16'h0016;
  localparam logic [15:0] AL_CODE_SYNC    = 16'h0035;
  localparam logic [15:0] AL_CODE_NONE    = 16'h0000;
  localparam logic [3:0]  MBX_OUT_CODE    = 4'h6;
  localparam logic [3:0]  MBX_IN_CODE     = 4'h2;
  localparam logic [15:0] MBX_MIN_LEN     = 16'h0020;
  localparam logic [16:0] MEM_START       = 17'h01000;
  localparam logic [16:0] MEM_END         = 17'h02000;
  localparam logic [31:0] REG_RESET       = 32'h00000000;

  // ****************************************************************
  // Supported cycle periods in ns.
  // ****************************************************************
  localparam logic [31:0] PERIOD_125US    = 32'h0001e848;
  localparam logic [31:0] PERIOD_250US    = 32'h0003d090;
  localparam logic [31:0] PERIOD_500US    = 32'h0007a120;
  localparam logic [31:0] PERIOD_1MS      = 32'h000f4240;
  localparam logic [31:0] PERIOD_2MS      = 32'h001e8480;
  localparam logic [31:0] PERIOD_4MS      = 32'h003d0900;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int          CLK_KHZ         = 250000;
  localparam int          BLINK_HALF_MS   = 200;
  localparam int          BLINK_HALF_CYC  = BLINK_HALF_MS * CLK_KHZ;

  typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} esm_state_t;

endpackage

// ### rtl/period_check.sv
// Tells whether a cycle time is one of the supported periods.
`timescale 1ns/1ns
module period_check (
  input  wire logic [31:0] period,
  output logic             supported
);

  assign supported = (period == cfg_check_pkg::PERIOD_125US) ||
                     (period == cfg_check_pkg::PERIOD_250US) ||
                     (period == cfg_check_pkg::PERIOD_500US) ||
                     (period == cfg_check_pkg::PERIOD_1MS)   ||
                     (period == cfg_check_pkg::PERIOD_2MS)   ||
                     (period == cfg_check_pkg::PERIOD_4MS);

endmodule

// ### rtl/range_overlap.sv
// Tells whether two byte ranges, each given as start and length, share a byte.
`timescale 1ns/1ns
module range_overlap (
  input  wire logic [15:0] a_start,
  input  wire logic [15:0] a_len,
  input  wire logic [15:0] b_start,
  input  wire logic [15:0] b_len,
  output logic             overlap
);

  logic [16:0] a_end;
  logic [16:0] b_end;

  assign a_end = {1'b0, a_start} + {1'b0, a_len};
  assign b_end = {1'b0, b_start} + {1'b0, b_len};

  // An empty range overlaps nothing.
  assign overlap = (a_len != 16'h0000) && (b_len != 16'h0000) &&
                   ({1'b0, a_start} < b_end) && ({1'b0, b_start} < a_end);

endmodule

// ### verification/smcc_assertions.sv
// Concurrent checks on the ports of the sync and mailbox setup checker.
`timescale 1ns/1ns
module smcc_assertions (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        err_led,
  input wire logic [3:0]  esm_state,
  input wire logic [15:0] al_status_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_one_wait: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait state not one cycle");
  a_code_legal: assert property (al_status_code inside {16'h0, 16'h16, 16'h35})
    else $error("unknown status code");
  a_sync_preop: assert property ($changed(al_status_code) && al_status_code == 16'h35
    |-> esm_state == 4'h2) else $error("sync alarm not in PreOP");
  a_mbx_init: assert property (al_status_code == 16'h16 |-> esm_state == 4'h1)
    else $error("mailbox alarm not in Init");
  a_latched_hold: assert property ($past(al_status_code) != 16'h0 |-> $stable(esm_state))
    else $error("state moved while alarm latched");
  a_op_source: assert property ($changed(esm_state) && esm_state == 4'h8
    |-> $past(esm_state) == 4'h4) else $error("OP not entered from SafeOP");
  a_led_dark: assert property (al_status_code == 16'h0 && $past(al_status_code) == 16'h0
    |-> !err_led) else $error("indicator lit without alarm");
  a_state_onehot: assert property ($onehot(esm_state)) else $error("state code not one-hot");
  c_op: cover property (esm_state == 4'h8);
  c_sync: cover property (al_status_code == 16'h35);
  c_led: cover property (err_led);
endmodule
bind sync_mailbox_config_checker smcc_assertions u_smcc_assertions (
  .clk_sys(clk_sys), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .err_led(err_led), .esm_state(esm_state),
  .al_status_code(al_status_code));

// ### verification/master_model.sv
// Register bus master standing in for the network master.
`timescale 1ns/1ns
module master_model (
  input  wire logic        clk_sys,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [11:0] avs_address = 12'h0,
  output logic             avs_read = 1'b0,
  output logic             avs_write = 1'b0,
  output logic      [31:0] avs_writedata = 32'h0,
  output logic      [3:0]  avs_byteenable = 4'hf,
  output logic             tmo = 1'b0
);
  // Called just after a rising edge; returns one edge after release.
  task automatic xfer(input logic rd, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    tmo <= (n == 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

// ### verification/sync_mailbox_config_checker_tb_top.sv
// Self-checking bench for the sync and mailbox setup checker.
`timescale 1ns/1ns
module sync_mailbox_config_checker_tb_top;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] avs_address;
  logic        avs_read, avs_write, avs_waitrequest, irq, err_led, tmo;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable, esm_state;
  logic [15:0] al_status_code;
  int          num_errors = 0;
  int          checked = 0;
  logic [31:0] gv [logic [11:0]];
  always #2 clk_sys = ~clk_sys;
  sync_mailbox_config_checker #(.BLINK_HALF_CYCLES(4)) u_sync_mailbox_config_checker (.*);
  master_model u_master_model (.*);
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_master_model.xfer(1'b0, a, d, q);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic st(input logic [3:0] s, input logic [15:0] c);
    logic [31:0] q;
    @(negedge clk_sys);
    chk("esm_state", {28'h0, s}, {28'h0, esm_state});
    chk("al_status_code", {16'h0, c}, {16'h0, al_status_code});
    @(posedge clk_sys);
    u_master_model.xfer(1'b1, 12'ha07, 32'h0, q);
    chk("status", {c, 6'h0, c == 16'h16, c == 16'h35, 4'h0, s}, q & 32'hfffffbff);
  endtask
  task automatic end_sim();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge tmo) begin
    num_errors++;
    end_sim();
  end
  task automatic t_setup();
    gv = '{12'h800:32'h1000, 12'h802:32'h20, 12'h804:32'h6, 12'h808:32'h1080,
           12'h80a:32'h20, 12'h80c:32'h2, 12'ha02:32'h1200, 12'ha03:32'h10,
           12'ha04:32'h1300, 12'ha05:32'h10};
    foreach (gv[a]) w(a, gv[a]);
    w(12'ha06, 32'h2);
    st(4'h2, 16'h0);
  endtask
  task automatic sy(input logic [1:0] m, input logic [31:0] r, o, input logic ok);
    w(12'ha01, {30'h0, m});
    w(12'h9a0, r);
    w(12'ha00, o);
    w(12'ha06, 32'h4);
    if (ok) begin
      st(4'h4, 16'h0);
      w(12'ha06, 32'h8);
      st(4'h8, 16'h0);
      w(12'ha06, 32'h2);
      st(4'h2, 16'h0);
    end else begin
      st(4'h2, 16'h35);
      w(12'ha06, 32'h4);
      st(4'h2, 16'h35);
      w(12'ha06, 32'h14);
      st(4'h2, 16'h0);
    end
  endtask
  task automatic t_sync();
    logic [31:0] p [6] = '{cfg_check_pkg::PERIOD_125US, cfg_check_pkg::PERIOD_250US,
      cfg_check_pkg::PERIOD_500US, cfg_check_pkg::PERIOD_1MS, cfg_check_pkg::PERIOD_2MS,
      cfg_check_pkg::PERIOD_4MS};
    foreach (p[i]) sy(2'h2, p[i], p[i], 1'b1);
    sy(2'h2, 32'h186a0, 32'h186a0, 1'b0);
    sy(2'h2, p[3], p[4], 1'b0);
    sy(2'h1, 32'h7b, p[2], 1'b1);
    sy(2'h1, p[3], 32'h1e847, 1'b0);
  endtask
  task automatic t_mbx();
    logic [43:0] bad [11] = '{{12'h800, 32'h1001}, {12'h800, 32'h0ff0},
      {12'h808, 32'h1081}, {12'h808, 32'h1010}, {12'h808, 32'h1200},
      {12'h800, 32'h1300}, {12'h802, 32'h1f}, {12'h80a, 32'h1f},
      {12'h804, 32'h2}, {12'h80c, 32'h6}, {12'h808, 32'h1ff0}};
    foreach (bad[i]) begin
      if (i % 2) w(bad[i][43:32], bad[i][31:0]);
      else begin
        w(12'ha06, 32'h1);
        w(bad[i][43:32], bad[i][31:0]);
        w(12'ha06, 32'h2);
      end
      st(4'h1, 16'h16);
      w(12'ha06, 32'h10);
      w(bad[i][43:32], gv[bad[i][43:32]]);
      w(12'ha06, 32'h2);
      st(4'h2, 16'h0);
    end
  endtask
  task automatic t_irq();
    logic [31:0] q;
    int          n;
    w(12'ha09, 32'h1);
    w(12'ha08, 32'h7);
    u_master_model.xfer(1'b1, 12'h100, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("irq", 32'h0, {31'h0, irq});
    w(12'ha01, 32'h2);
    w(12'h9a0, 32'h1);
    w(12'ha06, 32'h4);
    st(4'h2, 16'h35);
    chk("irq", 32'h1, {31'h0, irq});
    repeat (10) @(posedge clk_sys) n += err_led;
    chk("err_led blink", 32'h1, {31'h0, n > 0 && n < 10});
    w(12'ha08, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    st(4'h1, 16'h0);
    t_setup();
    t_sync();
    t_mbx();
    t_irq();
    end_sim();
  end
endmodule
